// *** design/dswp_map.vh ***
// Constants for the serial write port: word layout, modes, timing
`ifndef DSWP_MAP_VH
`define DSWP_MAP_VH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define DSWP_WORD_BITS 16
`define DSWP_CNT_BITS 5
`define DSWP_MODE_HI 13
`define DSWP_MODE_LO 12
`define DSWP_CODE_HI 11
`define DSWP_CODE_LO 2
`define DSWP_CODE_BITS 10

// ----------------------------------------------------------------
// Reset values and modes
// ----------------------------------------------------------------
`define DSWP_CODE_RST 10'h000
`define DSWP_CODE_FULL 10'h3ff
`define DSWP_MODE_NORMAL 2'h0
`define DSWP_MODE_PD_1K 2'h1
`define DSWP_MODE_PD_100K 2'h2
`define DSWP_MODE_PD_TRI 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DSWP_CLK_PERIOD_NS 50
`define DSWP_SEL_HIGH_MIN_NS 33

`endif

// *** design/dswp_serial_port.v ***
// Serial write port of a 10-bit converter: shift, decode, load
// Notes on behaviour
// - Sixteen-bit input shift register per frame
// - Sample data on shift clock falling edge
// - Low frame select enables shifting
// - Sixteenth falling edge loads code register
// - Early select rise aborts, clears shifter
// - Code is straight binary 000 to 3ff
// - Word: 2 dont-care, 2 mode, 10 code, 2 dont-care
// - Mode bits pick normal or power-down loads
// - Reset clears code; power-down frames still load it
`include "dswp_map.vh"

module dswp_serial_port #(
    parameter WORD_BITS = `DSWP_WORD_BITS
) (
    input wire ref_clk_in,
    input wire srst_in,
    input wire sync_n_in,
    input wire sclk_in,
    input wire din_in,
    output reg [`DSWP_CODE_BITS-1:0] dac_code_out,
    output reg [1:0] mode_out,
    output reg power_down_out,
    output reg pd_1k_out,
    output reg pd_100k_out,
    output reg pd_tristate_out,
    output reg update_out,
    output reg abort_out,
    output reg busy_out
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire [2:0] pins_s;
    wire sync_n_s;
    wire sclk_s;
    wire din_s;

    // Select idles high, clock and data low
    dswp_sync2 #(
        .WIDTH(3),
        .RST_VAL(3'h4)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .async_in({sync_n_in, sclk_in, din_in}),
        .sync_out(pins_s)
    );

    assign sync_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign din_s = pins_s[0];

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    reg sync_n_q;
    reg sclk_q;
    reg din_q;
    wire sclk_fall;
    wire sync_rise;

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            sync_n_q <= 1'b1;
            sclk_q <= 1'b0;
            din_q <= 1'b0;
        end else begin
            sync_n_q <= sync_n_s;
            sclk_q <= sclk_s;
            din_q <= din_s;
        end
    end

    assign sclk_fall = sclk_q & ~sclk_s;
    // Frames open on the select level, so only its rise is needed
    assign sync_rise = ~sync_n_q & sync_n_s;

    // ----------------------------------------------------------------
    // Frame state machine
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SHIFT = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;
    // Counter value seen at the last falling edge of a word
    localparam [31:0] LAST_IDX = WORD_BITS - 1;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [WORD_BITS-1:0] shift_q;
    reg [WORD_BITS-1:0] shift_d;
    reg [`DSWP_CNT_BITS-1:0] cnt_q;
    reg [`DSWP_CNT_BITS-1:0] cnt_d;
    reg load_d;
    reg abort_d;
    wire [WORD_BITS-1:0] word_next;
    wire last_bit;

    assign word_next = {shift_q[WORD_BITS-2:0], din_q};
    assign last_bit = (cnt_q == LAST_IDX[`DSWP_CNT_BITS-1:0]);

    always @* begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        load_d = 1'b0;
        abort_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (~sync_n_s) begin
                    state_d = ST_SHIFT;
                    cnt_d = {`DSWP_CNT_BITS{1'b0}};
                    shift_d = {WORD_BITS{1'b0}};
                end
            end
            ST_SHIFT: begin
                if (sync_rise) begin
                    state_d = ST_IDLE;
                    shift_d = {WORD_BITS{1'b0}};
                    cnt_d = {`DSWP_CNT_BITS{1'b0}};
                    abort_d = 1'b1;
                end else if (sclk_fall) begin
                    shift_d = word_next;
                    cnt_d = cnt_q + 1'b1;
                    if (last_bit) begin
                        load_d = 1'b1;
                        state_d = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                if (sync_n_s) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_q <= ST_IDLE;
            shift_q <= {WORD_BITS{1'b0}};
            cnt_q <= {`DSWP_CNT_BITS{1'b0}};
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Code and mode registers
    // ----------------------------------------------------------------
    // Decode from the word as it completes, so the load is one cycle
    wire [`DSWP_CODE_BITS-1:0] code_field;
    wire [1:0] mode_field;

    assign code_field = word_next[`DSWP_CODE_HI:`DSWP_CODE_LO];
    assign mode_field = {word_next[`DSWP_MODE_HI], word_next[`DSWP_MODE_LO]};

    // ----------------------------------------------------------------
    // Power-down load decode
    // ----------------------------------------------------------------
    // Bit n selects the load of power-down code n+1
    wire [2:0] load_sel;
    genvar gi;

    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_load_sel
            localparam [31:0] SEL_CODE = gi + 1;
            assign load_sel[gi] = (mode_field == SEL_CODE[1:0]);
        end
    endgenerate

    // Load selects move only with the code, so a cut frame keeps them
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            dac_code_out <= `DSWP_CODE_RST;
            mode_out <= `DSWP_MODE_NORMAL;
            power_down_out <= 1'b0;
            pd_1k_out <= 1'b0;
            pd_100k_out <= 1'b0;
            pd_tristate_out <= 1'b0;
            update_out <= 1'b0;
            abort_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            update_out <= load_d;
            abort_out <= abort_d;
            busy_out <= (state_d == ST_SHIFT);
            if (load_d) begin
                dac_code_out <= code_field;
                mode_out <= mode_field;
                power_down_out <= (mode_field != `DSWP_MODE_NORMAL);
                pd_1k_out <= load_sel[0];
                pd_100k_out <= load_sel[1];
                pd_tristate_out <= load_sel[2];
            end
        end
    end

endmodule // dswp_serial_port

// *** design/dswp_sync2.v ***
// Two-stage synchroniser for a group of pin inputs
module dswp_sync2 #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire ref_clk_in,
    input wire srst_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // dswp_sync2

// *** dv/dac_serial_write_port_test.sv ***
// Self-checking bench for the serial write port
module dac_serial_write_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    wire sync_n, sclk, din;
    wire [9:0] code;
    wire [1:0] mode;
    wire pd, pd1, pd100, pdt, upd, abt, busy;
    int err_total = 0;
    int checks_done = 0;
    int n_upd = 0;
    int n_abt = 0;
    logic [9:0] tab [4] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa};
    initial forever #25 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        if (upd === 1'b1) n_upd <= n_upd + 1;
        if (abt === 1'b1) n_abt <= n_abt + 1;
    end
    dswp_host host (.ref_clk_in(ref_clk_in), .sync_n_out(sync_n),
        .sclk_out(sclk), .din_out(din));
    dswp_serial_port dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .sync_n_in(sync_n), .sclk_in(sclk), .din_in(din),
        .dac_code_out(code), .mode_out(mode), .power_down_out(pd),
        .pd_1k_out(pd1), .pd_100k_out(pd100), .pd_tristate_out(pdt),
        .update_out(upd), .abort_out(abt), .busy_out(busy));
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic outs(input logic [9:0] c, input logic [1:0] m);
        chk("code", 16'(c), 16'(code));
        chk("mode", 16'(m), 16'(mode));
        chk("loads", 16'({m != 2'h0, m == 2'h3, m == 2'h2, m == 2'h1}),
            16'({pd, pdt, pd100, pd1}));
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            host.frame({2'b11, 2'(m), tab[m], 2'b11}, 16);
            outs(tab[m], 2'(m));
        end
        chk("updates", 16'd4, 16'(n_upd));
    endtask
    task automatic t_abort();
        host.frame(16'h1aa8, 10);
        outs(tab[3], 2'h3);
        chk("aborts", 16'd1, 16'(n_abt));
        host.frame(16'h0554, 16);
        outs(10'h155, 2'h0);
    endtask
    task automatic t_extra();
        host.frame(16'h2004, 20);
        outs(10'h001, 2'h2);
        chk("updates", 16'd6, 16'(n_upd));
    endtask
    initial begin
        repeat (2000) @(posedge ref_clk_in);
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (2) @(negedge ref_clk_in);
        srst_in = 1'b0;
        repeat (4) @(negedge ref_clk_in);
        outs(10'h000, 2'h0);
        chk("pulses", 16'h0, 16'({upd, abt, busy}));
        t_modes();
        t_abort();
        t_extra();
        give_verdict();
    end
endmodule // dac_serial_write_port_test
bind dswp_serial_port dswp_checker chk (.ref_clk_in(ref_clk_in),
    .srst_in(srst_in), .sync_n_in(sync_n_in), .sclk_in(sclk_in),
    .din_in(din_in), .dac_code_out(dac_code_out), .mode_out(mode_out),
    .power_down_out(power_down_out), .pd_1k_out(pd_1k_out),
    .pd_100k_out(pd_100k_out), .pd_tristate_out(pd_tristate_out),
    .update_out(update_out), .abort_out(abort_out), .busy_out(busy_out));

// *** dv/dswp_checker.sv ***
// Concurrent checks on the serial write port outputs
module dswp_checker (
    input wire ref_clk_in,
    input wire srst_in,
    input wire sync_n_in,
    input wire sclk_in,
    input wire din_in,
    input wire [9:0] dac_code_out,
    input wire [1:0] mode_out,
    input wire power_down_out,
    input wire pd_1k_out,
    input wire pd_100k_out,
    input wire pd_tristate_out,
    input wire update_out,
    input wire abort_out,
    input wire busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    pd_flag_a: assert property (power_down_out == (mode_out != 2'h0))
        else $error("power down flag disagrees with mode");
    pd_onehot_a: assert property ({pd_tristate_out, pd_100k_out,
        pd_1k_out} == (4'h8 >> (2'h3 - mode_out)) >> 1)
        else $error("load select decode wrong");
    code_hold_a: assert property (!update_out |-> $stable(dac_code_out))
        else $error("code moved without update");
    mode_hold_a: assert property (!update_out |-> $stable(mode_out))
        else $error("mode moved without update");
    upd_pulse_a: assert property (update_out |=> !update_out)
        else $error("update pulse too long");
    abort_pulse_a: assert property (abort_out |-> !update_out ##1 !abort_out)
        else $error("abort pulse wrong");
    abort_cause_a: assert property (abort_out |-> $past(sync_n_in, 2)
        || $past(sync_n_in, 3) || $past(sync_n_in, 4))
        else $error("abort without select rise");
    update_cause_a: assert property (update_out |-> !$past(sync_n_in, 5))
        else $error("update with select high");
    busy_rise_a: assert property ($rose(busy_out)
        |-> !$past(sync_n_in, 2))
        else $error("busy without select low");
    busy_drop_a: assert property (update_out || abort_out |-> !busy_out)
        else $error("busy still high at frame end");
    cover property (busy_out ##1 abort_out);
    cover property (update_out && mode_out == 2'h3);
    cover property (abort_out);
    cover property (update_out && dac_code_out == 10'h3ff);
endmodule // dswp_checker

// *** dv/dswp_host.sv ***
// Host model driving frame select, shift clock and data
module dswp_host (
    input wire ref_clk_in,
    output logic sync_n_out,
    output logic sclk_out,
    output logic din_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sync_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out = 1'b0;
    end
    // Half of the 400 ns shift clock period
    task automatic half();
        repeat (4) @(negedge ref_clk_in);
    endtask
    task automatic frame(input logic [15:0] w, input int n);
        sync_n_out = 1'b0;
        half();
        for (int k = 0; k < n; k++) begin
            din_out = w[15 - (k % 16)];
            sclk_out = 1'b1;
            half();
            sclk_out = 1'b0;
            half();
        end
        half();
        sync_n_out = 1'b1;
        // Line no longer held: show a changed level
        din_out = ~din_out;
        half();
        half();
    endtask
endmodule // dswp_host
